// *** rtl/data_buffer_flag_pointer_control.sv ***
// Output-stage flag, empty/last-word detect and pointers of the buffer
//
// Design decisions made here: the register offsets and the strobed register port.
`include "buffer_ctl_defines.svh"
`default_nettype none
module data_buffer_flag_pointer_control
    import buffer_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Register port
    input  wire reg_addr_t  reg_addr,
    input  wire reg_data_t  reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [15:0]     reg_rdata,
    // Asynchronous pins
    input  wire logic       xfer_strobe_pin,
    input  wire logic       power_clear_pin,
    // Neighbouring buffer logic
    input  wire logic [6:0] stage_full,
    input  wire logic       output_load,
    input  wire logic       mixer_word_clock,
    input  wire logic       word_mismatch,
    input  wire logic       mixer_step_pulse,
    input  wire logic       mem_clk_even,
    input  wire logic       mem_clk_odd,
    input  wire logic       assembly_step_pulse,
    input  wire logic       assembly_double,
    input  wire logic       double_request,
    input  wire logic       read_exception,
    input  wire logic       end_of_block_pulse,
    input  wire logic       drive_error,
    // Status outputs
    output logic            output_full,
    output logic            output_clear_pulse,
    output logic            drive_clock_pulse,
    output logic            mixer_pointer,
    output logic            odd_load_pointer,
    output logic            assembly_pointer,
    output logic            buffer_empty,
    output logic            final_word_flag,
    output logic            double_xfer_flag,
    output logic            transfer_stop,
    output logic            buffer_init
);
    localparam int OCLR_CYC   = `OCLR_CYC;
    localparam int DRVCLK_CYC = `DRVCLK_CYC;
    function automatic logic is_xfer(input op_mode_t op);
        return op != OP_MAINT;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    op_mode_t    op_r;
    logic        asi_r, baw_r, cmp_err_r, cmp_err_d;
    logic        init_r, host_strobe_r, drv_err_r, stop_r;
    logic        out_full_r, oclr_r, drv_clk_r, dbl_r;
    logic        mix_r, odd_r, asm_r, empty_r, last_r;
    logic [3:0]  oclr_cnt_r, drv_cnt_r;
    logic        mwc_d, mstep_d, memc_d, memboth_d, astep_d, adbl_d;
    logic [15:0] rdata_r;
    logic        pclr_rise;

    strobe_sync_if #(.W(2)) pins ();
    pin_sync #(.W(2)) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .pins_in  ({power_clear_pin, xfer_strobe_pin}),
        .sync     (pins)
    );
    logic pclr_d;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) pclr_d <= 1'b0;
        else         pclr_d <= pins.level[1];
    end
    assign pclr_rise = pins.level[1] & ~pclr_d;
    wire wr_ctrl  = reg_wr && reg_addr == `REG_CTRL;
    wire wr_cs2   = reg_wr && reg_addr == `REG_CS2;
    wire host_ini = (wr_ctrl && reg_wdata[`CTRL_INIT_BIT]) || pclr_rise;
    wire go_ini   = wr_ctrl && reg_wdata[`CTRL_GO_BIT];
    wire buf_out_sel = reg_rd && reg_addr == `REG_BUF && op_r == OP_MAINT;

    // ----------------------------------------------------------------
    // Control and init
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_r   <= OP_MAINT;
            asi_r  <= 1'b0;
            baw_r  <= 1'b0;
            init_r <= 1'b0;
        end else begin
            init_r <= host_ini || go_ini;
            if (wr_ctrl) begin
                op_r  <= op_mode_t'(reg_wdata[`CTRL_OP_LSB +: 2]);
                asi_r <= reg_wdata[`CTRL_ASI_BIT];
                baw_r <= reg_wdata[`CTRL_BAW_BIT];
            end
            // Go leaves the word bit alone; only host-side clears reset it
            if (host_ini) baw_r <= 1'b0;
        end
    end
    // Set wins over the software clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmp_err_r <= 1'b0;
            cmp_err_d <= 1'b0;
            mwc_d     <= 1'b0;
        end else begin
            mwc_d     <= mixer_word_clock;
            cmp_err_d <= cmp_err_r;
            if (mixer_word_clock && !mwc_d && op_r == OP_WCHECK &&
                word_mismatch)
                cmp_err_r <= 1'b1;
            else if (wr_cs2 && !reg_wdata[`CS2_CMP_BIT])
                cmp_err_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pulses built from counted delays, and the host buffer-read strobe
    // ----------------------------------------------------------------
    wire drv_end  = drv_clk_r && drv_cnt_r == 4'(DRVCLK_CYC - 1);
    wire oclr_end = oclr_r && oclr_cnt_r == 4'(OCLR_CYC - 1);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            drv_clk_r <= 1'b0;
            drv_cnt_r <= 4'h0;
        end else if (pins.fall[0]) begin
            drv_clk_r <= 1'b1;
            drv_cnt_r <= 4'h0;
        end else if (drv_end) begin
            drv_clk_r <= 1'b0;
        end else if (drv_clk_r) begin
            drv_cnt_r <= drv_cnt_r + 4'h1;
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            oclr_r     <= 1'b0;
            oclr_cnt_r <= 4'h0;
        end else if (op_r == OP_READ && assembly_step_pulse) begin
            oclr_r     <= 1'b1;
            oclr_cnt_r <= 4'h0;
        end else if (oclr_end) begin
            oclr_r     <= 1'b0;
        end else if (oclr_r) begin
            oclr_cnt_r <= oclr_cnt_r + 4'h1;
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) host_strobe_r <= 1'b0;
        else         host_strobe_r <= buf_out_sel;
    end

    // ----------------------------------------------------------------
    // Output-stage full flag
    // ----------------------------------------------------------------
    wire clr_wchk  = !mixer_word_clock && mwc_d && op_r == OP_WCHECK &&
                     !cmp_err_r;
    wire clr_write = drv_end && op_r == OP_WRITE && !stage_full[`SF_THIRD];
    wire clr_read  = oclr_end && op_r == OP_READ;
    wire clr_cmp   = !cmp_err_r && cmp_err_d;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)          out_full_r <= 1'b0;
        else if (init_r)      out_full_r <= 1'b0;
        else if (output_load) out_full_r <= 1'b1;
        else if (clr_wchk)    out_full_r <= 1'b0;
        else if (clr_cmp)     out_full_r <= 1'b0;
        else if (clr_write)   out_full_r <= 1'b0;
        else if (clr_read)    out_full_r <= 1'b0;
        else if (host_strobe_r) out_full_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Empty, last word, double transfer, stop
    // ----------------------------------------------------------------
    wire singles_empty = !(stage_full[`SF_FIRST] | stage_full[`SF_SECOND] |
                           stage_full[`SF_THIRD] | out_full_r);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            empty_r <= 1'b1;
            last_r  <= 1'b0;
            dbl_r   <= 1'b0;
        end else begin
            empty_r <= ~|{stage_full, out_full_r};
            last_r  <= singles_empty && (stage_full[`SF_ASM_EVEN] ^
                       stage_full[`SF_ASM_ODD]);
            dbl_r   <= double_request && !(last_r && read_exception);
        end
    end
    // Buffered words keep flowing; only new drive transfers stop
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            drv_err_r <= 1'b0;
            stop_r    <= 1'b0;
        end else if (init_r) begin
            drv_err_r <= 1'b0;
            stop_r    <= 1'b0;
        end else begin
            if (op_r == OP_READ && drive_error) drv_err_r <= 1'b1;
            if (end_of_block_pulse && (drv_err_r || drive_error) &&
                op_r == OP_READ)
                stop_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pointers, acting on trailing edges of their clocks
    // ----------------------------------------------------------------
    wire mix_fall  = !mixer_step_pulse && mstep_d;
    wire memc_fall = !(mem_clk_even | mem_clk_odd) && memc_d;
    wire asm_fall  = !assembly_step_pulse && astep_d;
    wire mix_hold  = is_xfer(op_r) && asi_r;
    wire odd_hold  = op_r == OP_READ && (asi_r || memboth_d || dbl_r);
    wire asm_hold  = ((op_r == OP_WRITE || op_r == OP_WCHECK) && adbl_d) ||
                     (is_xfer(op_r) && asi_r);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mstep_d   <= 1'b0;
            memc_d    <= 1'b0;
            memboth_d <= 1'b0;
            astep_d   <= 1'b0;
            adbl_d    <= 1'b0;
        end else begin
            mstep_d <= mixer_step_pulse;
            memc_d  <= mem_clk_even | mem_clk_odd;
            astep_d <= assembly_step_pulse;
            if (mem_clk_even | mem_clk_odd)
                memboth_d <= mem_clk_even & mem_clk_odd;
            if (assembly_step_pulse) adbl_d <= assembly_double;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)       mix_r <= 1'b0;
        else if (init_r)   mix_r <= baw_r;
        else if (mix_fall && !mix_hold)
            mix_r <= ~mix_r;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)       odd_r <= 1'b0;
        else if (init_r)   odd_r <= baw_r;
        else if (memc_fall && !odd_hold)
            odd_r <= ~odd_r;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)       asm_r <= 1'b0;
        else if (init_r)   asm_r <= baw_r;
        else if (asm_fall && !asm_hold)
            asm_r <= ~asm_r;
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL: rdata_r <= {10'h000, baw_r, 2'b00, asi_r, op_r};
                `REG_CS2:  rdata_r <= {1'b0, cmp_err_r, 14'h0000};
                `REG_STAT: rdata_r <= {7'h00, oclr_r, stop_r, asm_r, odd_r,
                                       mix_r, dbl_r, last_r, empty_r,
                                       out_full_r};
                `REG_BUF:  rdata_r <= {15'h0000, out_full_r};
                default:   rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end
    assign reg_rdata          = rdata_r;
    assign output_full        = out_full_r;
    assign output_clear_pulse = oclr_r;
    assign drive_clock_pulse  = drv_clk_r;
    assign mixer_pointer      = mix_r;
    assign odd_load_pointer   = odd_r;
    assign assembly_pointer   = asm_r;
    assign buffer_empty       = empty_r;
    assign final_word_flag    = last_r;
    assign double_xfer_flag   = dbl_r;
    assign transfer_stop      = stop_r;
    assign buffer_init        = init_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_init_clear;
        init_r |=> !out_full_r;
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("full flag survived buffer init");
    property p_wchk_clear;
        clr_wchk && !init_r && !output_load |=> !out_full_r;
    endproperty
    a_wchk_clear: assert property (p_wchk_clear)
        else $error("write-check trail did not clear full");
    property p_cmp_freeze;
        cmp_err_r && cmp_err_d && out_full_r && !init_r |=> out_full_r;
    endproperty
    a_cmp_freeze: assert property (p_cmp_freeze)
        else $error("full flag cleared during compare error");
    property p_read_pulse;
        op_r == OP_READ && assembly_step_pulse |=> oclr_r ##1 !oclr_r;
    endproperty
    a_read_pulse: assert property (p_read_pulse)
        else $error("output clear pulse length wrong");
    property p_empty;
        ##1 empty_r == $past(~|{stage_full, out_full_r});
    endproperty
    a_empty: assert property (p_empty)
        else $error("buffer empty mismatch");
    property p_last_both;
        stage_full[`SF_ASM_EVEN] && stage_full[`SF_ASM_ODD] |=> !last_r;
    endproperty
    a_last_both: assert property (p_last_both)
        else $error("last word with two assembly words");
    property p_dbl_block;
        last_r && read_exception |=> !dbl_r;
    endproperty
    a_dbl_block: assert property (p_dbl_block)
        else $error("double transfer set on last word");
    property p_mix_hold;
        is_xfer(op_r) && asi_r && !init_r |=> $stable(mix_r);
    endproperty
    a_mix_hold: assert property (p_mix_hold)
        else $error("mixer pointer moved under inhibit");
    property p_drive_clk;
        pins.fall[0] |=> drv_clk_r ##1 !drv_clk_r || pins.fall[0];
    endproperty
    a_drive_clk: assert property (p_drive_clk)
        else $error("drive clock pulse not from strobe trail");
    c_wchk: cover property (clr_wchk && out_full_r);
    c_cmp:  cover property (clr_cmp);
    c_last: cover property (last_r && read_exception);
endmodule // data_buffer_flag_pointer_control
`default_nettype wire

// *** rtl/buffer_ctl_defines.svh ***
// Offsets, field positions and timing counts for the buffer control block
`ifndef BUFFER_CTL_DEFINES_SVH
`define BUFFER_CTL_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CTRL       8'h00
`define REG_CS2        8'h04
`define REG_STAT       8'h08
`define REG_BUF        8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_OP_LSB    0
`define CTRL_ASI_BIT   2
`define CTRL_GO_BIT    3
`define CTRL_INIT_BIT  4
`define CTRL_BAW_BIT   5
`define CS2_CMP_BIT    14
`define SF_ASM_EVEN    0
`define SF_ASM_ODD     1
`define SF_MEM_EVEN    2
`define SF_MEM_ODD     3
`define SF_FIRST       4
`define SF_SECOND      5
`define SF_THIRD       6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ        10
`define OCLR_NS        50
`define DRVCLK_NS      50
`define OCLR_CYC   ((`OCLR_NS * `CLK_MHZ + 999) / 1000)
`define DRVCLK_CYC ((`DRVCLK_NS * `CLK_MHZ + 999) / 1000)

`endif

// *** rtl/buffer_ctl_pkg.sv ***
// Types shared by the buffer control block
`default_nettype none
package buffer_ctl_pkg;
    typedef enum logic [1:0] {
        OP_MAINT  = 2'b00,
        OP_WRITE  = 2'b01,
        OP_WCHECK = 2'b10,
        OP_READ   = 2'b11
    } op_mode_t;
    typedef logic [7:0]  reg_addr_t;
    typedef logic [15:0] reg_data_t;
endpackage
`default_nettype wire

// *** rtl/strobe_sync_if.sv ***
// Synchronised pin levels and their falling edges
`default_nettype none
interface strobe_sync_if #(parameter int W = 2);
    logic [W-1:0] level;
    logic [W-1:0] fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface
`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser with falling-edge detect for asynchronous pins
`default_nettype none
module pin_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // Raw pins
    input  wire logic [W-1:0] pins_in,
    // Synchronised side
    strobe_sync_if.src        sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] stable_r;
    logic [W-1:0] prev_r;

    // Only stable_r reads meta_r
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r   <= '0;
            stable_r <= '0;
            prev_r   <= '0;
        end else begin
            meta_r   <= pins_in;
            stable_r <= meta_r;
            prev_r   <= stable_r;
        end
    end

    assign sync.level = stable_r;
    assign sync.fall  = prev_r & ~stable_r;
endmodule // pin_sync
`default_nettype wire

// *** bench/drive_model.sv ***
// Behavioural tape drive: transfer strobes and an error level
`default_nettype none
module drive_model (
    // Link to the controller
    output var logic xfer_strobe,
    output var logic drive_fault
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        xfer_strobe = 1'b0;
        drive_fault = 1'b0;
    end

    // Strobe stands low between frames; odd start offset keeps its
    // edges away from the controller clock edges
    task automatic send(input int n);
        #137;
        repeat (n) begin
            #400 xfer_strobe = 1'b1;
            #400 xfer_strobe = 1'b0;
        end
    endtask

    // Error level moves just after an edge, never on it
    task automatic fault(input logic e);
        #1 drive_fault = e;
    endtask
endmodule // drive_model
`default_nettype wire

// *** bench/data_buffer_flag_pointer_control_tb_top.sv ***
// Self-checking bench for the buffer flag and pointer control
`include "buffer_ctl_defines.svh"
`default_nettype none
module data_buffer_flag_pointer_control_tb_top import buffer_ctl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    reg_addr_t   reg_addr = 8'h00;
    reg_data_t   reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        power_clear_pin = 1'b0;
    logic [6:0]  stage_full = 7'h00;
    logic [7:0]  pul = 8'h00;
    logic        assembly_double = 1'b0;
    logic        word_mismatch = 1'b0;
    logic        double_request = 1'b0;
    logic        read_exception = 1'b0;
    logic        xfer_strobe, drive_fault;
    logic [15:0] reg_rdata, v;
    logic        output_full, output_clear_pulse, drive_clock_pulse;
    logic        mixer_pointer, odd_load_pointer, assembly_pointer;
    logic        buffer_empty, final_word_flag, double_xfer_flag;
    logic        transfer_stop, buffer_init;
    logic [2:0]  ptrs, exp_p;
    logic [15:0] cs;
    int          fail_count = 0;
    int          compares = 0;
    int          cyc = 0;
    int          dcp_count = 0;
    int          init_count = 0;
    int          n;
    integer      seed = 32'h2207_7d02;
    // Per case: [14] hold, [13:12] pointer, [11] double load,
    // [10] step inhibit, [9:8] mode, [7:0] pulse mask
    localparam logic [15:0] CASES [9] = '{16'h2404, 16'h6504, 16'h2104,
        16'h1308, 16'h5708, 16'h5318, 16'h0120, 16'h4920, 16'h4620};

    assign ptrs = {mixer_pointer, odd_load_pointer, assembly_pointer};

    always #50 core_clk = ~core_clk;

    data_buffer_flag_pointer_control DUT (
        .core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .xfer_strobe_pin(xfer_strobe), .power_clear_pin,
        .stage_full, .output_load(pul[0]), .mixer_word_clock(pul[1]),
        .word_mismatch, .mixer_step_pulse(pul[2]), .mem_clk_even(pul[3]),
        .mem_clk_odd(pul[4]), .assembly_step_pulse(pul[5]),
        .assembly_double, .double_request, .read_exception,
        .end_of_block_pulse(pul[6]), .drive_error(drive_fault),
        .output_full, .output_clear_pulse, .drive_clock_pulse,
        .mixer_pointer, .odd_load_pointer, .assembly_pointer,
        .buffer_empty, .final_word_flag, .double_xfer_flag,
        .transfer_stop, .buffer_init
    );

    drive_model drv (.xfer_strobe, .drive_fault);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    task automatic reg_write(input reg_addr_t a, input reg_data_t d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        tick(3);
    endtask

    // Data stand only in the cycle after the strobe
    task automatic reg_read(input reg_addr_t a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // f = {word bit, host init, go, step inhibit}
    task automatic ctrl(input op_mode_t op, input logic [3:0] f);
        reg_write(`REG_CTRL, {10'h000, f, op});
    endtask

    task automatic pulse(input logic [7:0] m);
        @(posedge core_clk);
        pul <= m;
        @(posedge core_clk);
        pul <= 8'h00;
    endtask

    function automatic logic fw(input logic [6:0] s);
        return s[6:4] == 3'b000 && (s[0] ^ s[1]);
    endfunction

    always @(posedge core_clk) begin
        cyc++;
        if (drive_clock_pulse === 1'b1) dcp_count++;
        if (buffer_init === 1'b1) init_count++;
        if (cyc == 20000) begin
            fail_count++;
            test_done;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(20);
        arst_n <= 1'b1;
        @(negedge core_clk);
        chk(buffer_empty, 1'b1);
        chk(output_full, 1'b0);
        ctrl(OP_MAINT, 4'b1010);
        chk(ptrs, 3'b111);
        @(posedge core_clk);
        power_clear_pin <= 1'b1;
        tick(6);
        power_clear_pin <= 1'b0;
        tick(2);
        chk(ptrs, 3'b000);
        reg_read(`REG_CTRL, v);
        chk(v[5], 1'b0);
        ctrl(OP_MAINT, 4'b1010);
        ctrl(OP_MAINT, 4'b0100);
        chk(ptrs, 3'b000);
        exp_p = 3'b000;
        foreach (CASES[i]) begin
            cs = CASES[i];
            ctrl(op_mode_t'(cs[9:8]), {3'b000, cs[10]});
            assembly_double <= cs[11];
            n = 1 + ($unsigned($random(seed)) % 4);
            repeat (n) begin
                pulse(cs[7:0]);
                tick(1);
            end
            tick(2);
            assembly_double <= 1'b0;
            if (!cs[14]) exp_p[cs[13:12]] = exp_p[cs[13:12]] ^ n[0];
            chk(ptrs, exp_p);
        end
        ctrl(OP_MAINT, 4'b0100);
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            stage_full <= i == 0 ? 7'h00 : i == 1 ? 7'h03 : i == 2 ?
                7'h0e : i == 3 ? 7'h11 : 7'($random(seed));
            tick(3);
            chk(buffer_empty, stage_full == 7'h00);
            chk(final_word_flag, fw(stage_full));
        end
        stage_full <= 7'h01;
        double_request <= 1'b1;
        read_exception <= 1'b1;
        tick(3);
        chk(double_xfer_flag, 1'b0);
        read_exception <= 1'b0;
        tick(3);
        chk(double_xfer_flag, 1'b1);
        double_request <= 1'b0;
        stage_full <= 7'h00;
        // Read: assembly load clears the output stage
        ctrl(OP_READ, 4'h0);
        pulse(8'h01);
        tick(2);
        chk(output_full, 1'b1);
        pulse(8'h20);
        @(negedge core_clk);
        chk({output_clear_pulse, output_full}, 2'b11);
        @(negedge core_clk);
        chk({output_clear_pulse, output_full}, 2'b00);
        // Maintenance: host reads the buffer word
        ctrl(OP_MAINT, 4'h0);
        pulse(8'h01);
        tick(2);
        reg_read(`REG_BUF, v);
        chk(v[0], 1'b1);
        tick(3);
        chk(output_full, 1'b0);
        // Write: a word still in the third stage keeps the flag
        ctrl(OP_WRITE, 4'h0);
        pulse(8'h01);
        stage_full <= 7'h40;
        drv.send(1);
        tick(8);
        chk(output_full, 1'b1);
        stage_full <= 7'h00;
        drv.send(2);
        tick(8);
        chk(output_full, 1'b0);
        chk(dcp_count, 3);
        // Write-check: clean compare, then a mismatch
        ctrl(OP_WCHECK, 4'h0);
        pulse(8'h01);
        tick(2);
        pulse(8'h02);
        tick(3);
        chk(output_full, 1'b0);
        pulse(8'h01);
        word_mismatch <= 1'b1;
        tick(2);
        pulse(8'h02);
        tick(3);
        word_mismatch <= 1'b0;
        chk(output_full, 1'b1);
        reg_read(8'h04, v);
        chk(v[14], 1'b1);
        reg_write(8'h04, 16'h0000);
        chk(output_full, 1'b0);
        pulse(8'h01);
        tick(2);
        ctrl(OP_WCHECK, 4'b0010);
        chk(output_full, 1'b0);
        // Drive error stops a read at the block end
        ctrl(OP_READ, 4'h0);
        drv.fault(1'b1);
        tick(4);
        chk(transfer_stop, 1'b0);
        pulse(8'h40);
        tick(2);
        chk(transfer_stop, 1'b1);
        drv.fault(1'b0);
        reg_read(8'h10, v);
        chk(v, 16'h0000);
        chk(init_count, 6);
        test_done;
    end
endmodule // data_buffer_flag_pointer_control_tb_top
`default_nettype wire
